// ---- verilog/epmux_top.sv ----
// pin multiplexer for expansion ports a and b
`timescale 1ns/100ps
// Behaviour
// - one function select bit per port
// - port a: sixteen gpio pins, entry 0
// - port b: sixteen gpio pins, five of them muxable, entry 1
// - serial tx select moves console tx to port b; rx select alone only switches console tx off
// - console receive always stays working
// - two serial ports: reroute secondary only
// - pwm enable drives pwm 0..2 onto b0..2
// - console runs 115200 baud, 8n1
// - console enable false switches console tx off
module epmux_top #(
  parameter bit TWO_SERIAL = 1'b0
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // system control container bits
  input  wire logic        port_a_function_select_bit_i,
  input  wire logic        port_b_function_select_bit_i,
  input  wire logic        pwm_output_enable_i,
  input  wire logic        serial_tx_select_i,
  input  wire logic        serial_rx_select_i,
  input  wire logic        console_enable_i,
  // gpio register side, entries 0 and 1
  input  wire logic [15:0] gpio_a_out_i,
  input  wire logic [15:0] gpio_a_dir_i,
  output logic      [15:0] gpio_a_in_o,
  input  wire logic [15:0] gpio_b_out_i,
  input  wire logic [15:0] gpio_b_dir_i,
  output logic      [15:0] gpio_b_in_o,
  // peripherals
  input  wire logic [2:0]  pwm_i,
  input  wire logic        primary_serial_port_tx_i,
  output logic             primary_serial_port_rx_o,
  input  wire logic        secondary_serial_port_tx_i,
  output logic             secondary_serial_port_rx_o,
  // console usb serial path
  output logic             console_tx_o,
  input  wire logic        console_rx_i,
  // expansion header pins
  input  wire logic [15:0] port_a_i,
  output logic      [15:0] port_a_o,
  output logic      [15:0] port_a_oe_o,
  input  wire logic [15:0] port_b_i,
  output logic      [15:0] port_b_o,
  output logic      [15:0] port_b_oe_o
);
  // synchronised pin levels
  logic [15:0] a_sync;
  logic [15:0] b_sync;
  logic        con_rx_sync;
  // port a registers
  logic [15:0] port_a_out_r;
  logic [15:0] port_a_out_nxt;
  logic [15:0] port_a_oe_r;
  logic [15:0] port_a_oe_nxt;
  // port b registers and peripheral overlay
  logic [15:0] port_b_out_r;
  logic [15:0] port_b_out_nxt;
  logic [15:0] port_b_oe_r;
  logic [15:0] port_b_oe_nxt;
  logic [15:0] b_per_out;
  logic [15:0] b_per_oe;
  logic [15:0] b_own_out;
  logic [15:0] b_own_oe;
  logic        routed_tx;
  // serial line registers
  logic        rerouted;
  logic        console_tx_r;
  logic        console_tx_nxt;
  logic        pri_rx_r;
  logic        pri_rx_nxt;
  logic        sec_rx_r;
  logic        sec_rx_nxt;
  // gpio readback registers
  logic [15:0] gpio_a_in_r;
  logic [15:0] gpio_a_in_nxt;
  logic [15:0] gpio_b_in_r;
  logic [15:0] gpio_b_in_nxt;

  // a set select hands every pin in own to the peripheral, the rest stay gpio
  function automatic logic [15:0] take_pins(
    input logic        sel,
    input logic [15:0] gpio,
    input logic [15:0] periph,
    input logic [15:0] own
  );
    logic [15:0] taken;
    taken     = sel ? own : 16'h0000;
    take_pins = (gpio & ~taken) | (periph & taken);
  endfunction

  // a port b peripheral flag only counts while the port b select is set
  function automatic logic b_flag(
    input logic sel,
    input logic flag
  );
    b_flag = sel & flag;
  endfunction

  epmux_sync #(.W(16), .RST(epmux_pkg::PORT_RST)) u_sync_a (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .d_i       (port_a_i),
    .q_o       (a_sync)
  );

  epmux_sync #(.W(16), .RST(epmux_pkg::PORT_RST)) u_sync_b (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .d_i       (port_b_i),
    .q_o       (b_sync)
  );

  epmux_sync #(.W(1), .RST(epmux_pkg::SER_IDLE)) u_sync_rx (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .d_i       (console_rx_i),
    .q_o       (con_rx_sync)
  );

  // port a has no peripheral mapped, so its select leaves every pin as gpio
  always_comb begin
    port_a_out_nxt = take_pins(port_a_function_select_bit_i, gpio_a_out_i,
                               16'h0000, 16'h0000);
    port_a_oe_nxt  = take_pins(port_a_function_select_bit_i, gpio_a_dir_i,
                               16'h0000, 16'h0000);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      port_a_out_r <= epmux_pkg::PORT_RST;
      port_a_oe_r  <= epmux_pkg::PORT_RST;
    end else begin
      port_a_out_r <= port_a_out_nxt;
      port_a_oe_r  <= port_a_oe_nxt;
    end
  end

  // port b overlay: what each peripheral drives, and which pins it claims
  always_comb begin
    routed_tx = TWO_SERIAL ? secondary_serial_port_tx_i : primary_serial_port_tx_i;
    b_per_out = 16'h0000;
    b_per_oe  = 16'h0000;
    b_own_out = 16'h0000;
    b_own_oe  = 16'h0000;
    if (pwm_output_enable_i) begin
      b_per_out[epmux_pkg::PWM_LSB +: epmux_pkg::PWM_N] = pwm_i;
      b_per_oe[epmux_pkg::PWM_LSB +: epmux_pkg::PWM_N]  = {epmux_pkg::PWM_N{1'b1}};
      b_own_out[epmux_pkg::PWM_LSB +: epmux_pkg::PWM_N] = {epmux_pkg::PWM_N{1'b1}};
      b_own_oe[epmux_pkg::PWM_LSB +: epmux_pkg::PWM_N]  = {epmux_pkg::PWM_N{1'b1}};
    end
    if (serial_tx_select_i) begin
      b_per_out[epmux_pkg::SER_TX_BIT] = routed_tx;
      b_per_oe[epmux_pkg::SER_TX_BIT]  = 1'b1;
      b_own_out[epmux_pkg::SER_TX_BIT] = 1'b1;
      b_own_oe[epmux_pkg::SER_TX_BIT]  = 1'b1;
    end
    if (serial_rx_select_i) begin
      // the rx pin only turns into an input; its output level stays the gpio's
      b_own_oe[epmux_pkg::SER_RX_BIT] = 1'b1;
    end
    port_b_out_nxt = take_pins(port_b_function_select_bit_i, gpio_b_out_i,
                               b_per_out, b_own_out);
    port_b_oe_nxt  = take_pins(port_b_function_select_bit_i, gpio_b_dir_i,
                               b_per_oe, b_own_oe);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      port_b_out_r <= epmux_pkg::PORT_RST;
      port_b_oe_r  <= epmux_pkg::PORT_RST;
    end else begin
      port_b_out_r <= port_b_out_nxt;
      port_b_oe_r  <= port_b_oe_nxt;
    end
  end

  // serial framing (115200 8n1) lives in the serial ports; this block only steers lines
  always_comb begin
    rerouted       = b_flag(port_b_function_select_bit_i,
                            serial_tx_select_i | serial_rx_select_i);
    console_tx_nxt = epmux_pkg::SER_IDLE;
    // console tx leaves the default path when switched off, or when rerouted and TWO_SERIAL is clear
    if (console_enable_i && !(rerouted && !TWO_SERIAL)) begin
      console_tx_nxt = primary_serial_port_tx_i;
    end
    pri_rx_nxt     = con_rx_sync;
    sec_rx_nxt     = epmux_pkg::SER_IDLE;
    if (b_flag(port_b_function_select_bit_i, serial_rx_select_i)) begin
      if (TWO_SERIAL) begin
        sec_rx_nxt = b_sync[epmux_pkg::SER_RX_BIT];
      end else begin
        // either source may pull the shared receive line low
        pri_rx_nxt = con_rx_sync & b_sync[epmux_pkg::SER_RX_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      console_tx_r <= epmux_pkg::SER_IDLE;
      pri_rx_r     <= epmux_pkg::SER_IDLE;
      sec_rx_r     <= epmux_pkg::SER_IDLE;
    end else begin
      console_tx_r <= console_tx_nxt;
      pri_rx_r     <= pri_rx_nxt;
      sec_rx_r     <= sec_rx_nxt;
    end
  end

  // gpio readback: synchronised pin levels through one more register stage
  always_comb begin
    gpio_a_in_nxt = a_sync;
    gpio_b_in_nxt = b_sync;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gpio_a_in_r <= epmux_pkg::PORT_RST;
      gpio_b_in_r <= epmux_pkg::PORT_RST;
    end else begin
      gpio_a_in_r <= gpio_a_in_nxt;
      gpio_b_in_r <= gpio_b_in_nxt;
    end
  end

  // every output is a plain copy of a register
  assign port_a_o                   = port_a_out_r;
  assign port_a_oe_o                = port_a_oe_r;
  assign port_b_o                   = port_b_out_r;
  assign port_b_oe_o                = port_b_oe_r;
  assign gpio_a_in_o                = gpio_a_in_r;
  assign gpio_b_in_o                = gpio_b_in_r;
  assign console_tx_o               = console_tx_r;
  assign primary_serial_port_rx_o   = pri_rx_r;
  assign secondary_serial_port_rx_o = sec_rx_r;
endmodule

// ---- verilog/epmux_pkg.sv ----
// constants for the expansion port pin multiplexer
package epmux_pkg;
  localparam int          PORT_W        = 16;
  localparam int          PWM_N         = 3;
  localparam int          PWM_LSB       = 0;
  localparam int          SER_RX_BIT    = 8;
  localparam int          SER_TX_BIT    = 9;
  localparam int          CLK_HZ        = 100000000;
  localparam int          BAUD          = 115200;
  localparam int          BAUD_DIV      = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int          DATA_BITS     = 8;
  localparam logic [15:0] PORT_RST      = 16'h0000;
  localparam logic        SER_IDLE      = 1'b1;
endpackage

// ---- verilog/epmux_sync.sv ----
// two-flop synchroniser for a bus of pin inputs
`timescale 1ns/100ps
module epmux_sync #(
  parameter int W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         reset_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= RST;
      q_o    <= RST;
    end else begin
      meta_r <= meta_nxt;
      q_o    <= q_nxt;
    end
  end
endmodule

// ---- test/epmux_chk_sva.sv ----
// port assertions for the pin multiplexer
`timescale 1ns/100ps
module epmux_chk (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  // select flags and control bits
  input wire logic        port_b_function_select_bit_i,
  input wire logic        pwm_output_enable_i,
  input wire logic        serial_tx_select_i,
  input wire logic        serial_rx_select_i,
  input wire logic        console_enable_i,
  // serial and console lines
  input wire logic        console_rx_i,
  input wire logic        primary_serial_port_tx_i,
  input wire logic        console_tx_o,
  input wire logic        primary_serial_port_rx_o,
  // pwm and gpio direction
  input wire logic [2:0]  pwm_i,
  input wire logic [15:0] gpio_a_dir_i,
  input wire logic [15:0] gpio_b_dir_i,
  // header pin outputs
  input wire logic [15:0] port_a_oe_o,
  input wire logic [15:0] port_b_o,
  input wire logic [15:0] port_b_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire logic b = port_b_function_select_bit_i;
  AST_A_DIR: assert property (port_a_oe_o == $past(gpio_a_dir_i)) else $error("a dir");
  AST_B_GPIO: assert property (!$past(b) |-> port_b_oe_o == $past(gpio_b_dir_i))
    else $error("b dir");
  AST_PWM: assert property ($past(b & pwm_output_enable_i) |->
    port_b_o[2:0] == $past(pwm_i) && port_b_oe_o[2:0] == 3'h7) else $error("pwm");
  AST_TX_PIN: assert property ($past(b & serial_tx_select_i) |->
    port_b_o[9] == $past(primary_serial_port_tx_i) && port_b_oe_o[9]) else $error("tx pin");
  AST_RX_PIN: assert property ($past(b & serial_rx_select_i) |-> !port_b_oe_o[8])
    else $error("rx pin");
  AST_TX_OFF: assert property ($past(b & (serial_tx_select_i | serial_rx_select_i))
    |-> console_tx_o) else $error("tx moved");
  AST_CON_OFF: assert property (!$past(console_enable_i) |-> console_tx_o)
    else $error("console off");
  AST_RX_KEEP: assert property (!$past(console_rx_i, 3) |-> !primary_serial_port_rx_o)
    else $error("rx lost");
endmodule
bind epmux_top epmux_chk epmux_chk_inst (.*);

// ---- test/epmux_pins.sv ----
// header pins: outside hardware drives each line the port releases
`timescale 1ns/100ps
module epmux_pins (
  // levels and enables the block puts on the header
  input  wire logic [15:0] port_a_o,
  input  wire logic [15:0] port_a_oe_o,
  input  wire logic [15:0] port_b_o,
  input  wire logic [15:0] port_b_oe_o,
  // levels the outside hardware puts on released lines
  input  wire logic [15:0] ext_a,
  input  wire logic [15:0] ext_b,
  // levels seen back at the block's pin inputs
  output logic      [15:0] port_a_i,
  output logic      [15:0] port_b_i
);
  assign port_a_i = port_a_oe_o & port_a_o | ~port_a_oe_o & ext_a;
  assign port_b_i = port_b_oe_o & port_b_o | ~port_b_oe_o & ext_b;
endmodule

// ---- test/tb_top.sv ----
// random and corner-case bench for the pin multiplexer
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module tb_top;
  logic sys_clk_i = 0, reset_i = 1, console_enable_i, console_rx_i, port_a_function_select_bit_i;
  logic port_b_function_select_bit_i, pwm_output_enable_i, serial_tx_select_i, serial_rx_select_i;
  logic primary_serial_port_tx_i, secondary_serial_port_tx_i;
  logic [2:0] pwm_i, hr = 3'h7;
  logic [15:0] gpio_a_out_i, gpio_a_dir_i, gpio_b_out_i, gpio_b_dir_i, ext_a, ext_b;
  logic [2:0][15:0] ha = '0, hb = '0;
  wire logic [15:0] gpio_a_in_o, gpio_b_in_o, port_a_i, port_a_o, port_a_oe_o;
  wire logic [15:0] port_b_i, port_b_o, port_b_oe_o;
  wire logic primary_serial_port_rx_o, secondary_serial_port_rx_o, console_tx_o;
  logic [31:0] seed = 32'h9B44D483;
  int n_fail = 0, n_compared = 0, cyc = 0;
  epmux_top epmux_top_inst (.*);
  epmux_pins epmux_pins_inst (.*);
  always #5 sys_clk_i = ~sys_clk_i;
  task automatic final_report();
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // port b pin levels and enables from the select flags
  function automatic logic [31:0] exp_b();
    logic [15:0] o, d;
    o = gpio_b_out_i;
    d = gpio_b_dir_i;
    if (port_b_function_select_bit_i) begin
      if (pwm_output_enable_i) {o[2:0], d[2:0]} = {pwm_i, 3'h7};
      if (serial_tx_select_i) {o[9], d[9]} = {primary_serial_port_tx_i, 1'b1};
      if (serial_rx_select_i) d[8] = 1'b0;
    end
    return {d, o};
  endfunction
  // ph -1 quiet, 0 random, 1 all port b flags set, 2 port b select clear
  task automatic drive(int ph);
    logic [31:0] r;
    r = (ph < 0) ? 32'hC00 : rnd() | (ph == 1 ? 32'h1E : 32'h0);
    if (ph == 2) r[1] = 1'b0;
    {console_rx_i, console_enable_i, pwm_i, secondary_serial_port_tx_i, primary_serial_port_tx_i,
     serial_rx_select_i, serial_tx_select_i, pwm_output_enable_i, port_b_function_select_bit_i,
     port_a_function_select_bit_i} = r[11:0];
    {gpio_a_out_i, gpio_a_dir_i} = (ph < 0) ? 32'h0 : rnd();
    {gpio_b_out_i, gpio_b_dir_i} = (ph < 0) ? 32'h0 : rnd();
    {ext_a, ext_b} = (ph < 0) ? 32'h0 : rnd();
  endtask
  task automatic check();
    logic [31:0] x;
    logic        ec;
    logic        er;
    x  = exp_b();
    // console tx idles when switched off or rerouted to port b
    ec = !console_enable_i || primary_serial_port_tx_i ||
         port_b_function_select_bit_i && (serial_tx_select_i || serial_rx_select_i);
    // console rx and the port b rx pin share the primary receive line
    er = hr[2] && (!(port_b_function_select_bit_i && serial_rx_select_i) || hb[2][8]);
    `CHK("port_a_oe", gpio_a_dir_i, port_a_oe_o)
    `CHK("port_a", gpio_a_out_i & gpio_a_dir_i, port_a_o & port_a_oe_o)
    `CHK("port_b_oe", x[31:16], port_b_oe_o)
    `CHK("port_b", x[15:0] & x[31:16], port_b_o & port_b_oe_o)
    `CHK("console_tx", ec, console_tx_o)
    `CHK("gpio_a_in", ha[2], gpio_a_in_o)
    `CHK("gpio_b_in", hb[2], gpio_b_in_o)
    if (!hr[2]) `CHK("primary_rx", 1'b0, primary_serial_port_rx_o)
    `CHK("primary_rx_pin", er, primary_serial_port_rx_o)
    `CHK("secondary_rx", 1'b1, secondary_serial_port_rx_o)
  endtask
  always @(posedge sys_clk_i) begin
    ha <= {ha[1:0], port_a_i};
    hr <= {hr[1:0], console_rx_i};
    hb <= {hb[1:0], port_b_i};
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    drive(-1);
    repeat (5) @(posedge sys_clk_i);
    #1 reset_i = 0;
    for (int i = 0; i < 900; i++) begin
      @(posedge sys_clk_i);
      #1 check();
      drive(i / 300);
    end
    final_report();
  end
endmodule
